// *** hdl/perr_port_events.sv ***
// per-port event detection, status flags, interrupt and port-write request
`default_nettype none
`include "perr_defs.svh"
// Contract
// - a fabric request timeout drops the packet, sets the fabric timeout flag, may interrupt and port-write.
// - a fabric timeout also sets the egress discard, fabric interrupt and global timeout bits.
// - a multicast buffer placement timeout sets the multicast timeout flag, may interrupt and port-write.
// - four successive link-requests answered with no ackID outstanding set the fatal fault flag.
// - four successive link-requests whose response wait times out set the fatal fault flag.
// - link loss timer expiry sets the fatal fault flag, which may interrupt and port-write.
// - lane alignment timer expiry on any lane of the port sets the fatal fault flag.
// - every link-request response timeout also sets the ack timeout flag in error detect.
// - every link-response with no ackID outstanding also sets the bad response id flag.
// - finishing initialization after a peer is found sets the peer ready flag, may interrupt.
// - a bad ackID in an accepted, not-accepted or retry symbol sets the symbol bad id flag.
module perr_port_events #(
  parameter int LANES = 4,
  parameter int FAB_W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // event inputs from the link and the switch fabric
  input wire perr_pkg::perr_events_t events,
  // fabric drop strobe back to the egress path
  output logic dropPacket,
  // register bus
  input wire perr_pkg::perr_axi_req_t axiReq,
  output perr_pkg::perr_axi_rsp_t axiRsp,
  // notifications
  output logic irq,
  output logic portWriteReq,
  input wire logic portWriteAck
);
  typedef struct packed {
    logic [`PERR_PI_W-1:0] intMask;
    logic [`PERR_PI_W-1:0] pwMask;
    logic [1:0] ctrl;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic pwPending;
    logic drop;
  } perr_top_state_t;

  perr_top_state_t st_reg;
  perr_top_state_t st_next;

  logic [`PERR_PI_W-1:0] portInt;
  logic [`PERR_ED_W-1:0] errDet;
  logic [`PERR_ES_W-1:0] errStat;
  logic [FAB_W-1:0] fabInt;
  logic [`PERR_GI_W-1:0] glbInt;
  logic [`PERR_PI_W-1:0] piSet;
  logic [`PERR_PI_W-1:0] piClr;
  logic [`PERR_ED_W-1:0] edSet;
  logic [`PERR_ED_W-1:0] edClr;
  logic [`PERR_ES_W-1:0] esSet;
  logic [`PERR_ES_W-1:0] esClr;
  logic [FAB_W-1:0] fabSet;
  logic [FAB_W-1:0] fabClr;
  logic [`PERR_GI_W-1:0] giSet;
  logic [`PERR_GI_W-1:0] giClr;
  logic respFatal;
  logic toFatal;
  logic [2:0] respCount;
  logic [2:0] toCount;
  logic fatalEvent;
  logic readTake;
  logic writeTake;
  logic [7:0] rdAddr;

  // word-aligned offset compare, used by both read and write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction : hit

  function automatic logic known(input logic [7:0] addr);
    known = hit(addr, `PERR_OFF_PORT_INT) || hit(addr, `PERR_OFF_PORT_MASK) ||
            hit(addr, `PERR_OFF_ERR_DET) || hit(addr, `PERR_OFF_ERR_STAT) ||
            hit(addr, `PERR_OFF_FAB_INT) || hit(addr, `PERR_OFF_GLB_INT) ||
            hit(addr, `PERR_OFF_PW_MASK) || hit(addr, `PERR_OFF_CTRL) ||
            hit(addr, `PERR_OFF_RETRY);
  endfunction : known

  // link-request retry outcome counters, one per failure kind
  perr_retry_tracker u_resp_tracker (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .attemptFailed(events.linkReqResp && events.responseNoAck),
    .attemptGood(events.linkReqResp && !events.responseNoAck),
    .clearDead(writeTake && hit(st_reg.awAddr, `PERR_OFF_ERR_STAT)),
    .fatalPulse(respFatal),
    .failCount(respCount)
  );

  perr_retry_tracker u_to_tracker (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .attemptFailed(events.linkReqTimeout),
    .attemptGood(events.linkReqResp),
    .clearDead(writeTake && hit(st_reg.awAddr, `PERR_OFF_ERR_STAT)),
    .fatalPulse(toFatal),
    .failCount(toCount)
  );

  // ctrl[0] enables fabric drop on timeout, ctrl[1] enables port-writes
  assign fatalEvent = respFatal || toFatal || events.linkLossExpired
                      || (|events.laneAlignExpired[LANES-1:0]);

  assign readTake = axiReq.arvalid && !st_reg.rValid;
  assign rdAddr = axiReq.araddr;
  assign writeTake = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;

  always_comb begin
    piSet = '0;
    piSet[`PERR_PI_FABRIC_TO] = events.fabricTimeout;
    piSet[`PERR_PI_MCAST_TO] = events.mcastTimeout;
    piSet[`PERR_PI_PEER_READY] = events.peerReady;
    piSet[`PERR_PI_FATAL] = fatalEvent;
    edSet = '0;
    edSet[`PERR_ED_ACK_TO] = events.linkReqTimeout;
    edSet[`PERR_ED_BAD_RESP] = events.linkReqResp && events.responseNoAck;
    edSet[`PERR_ED_SYM_BAD] = events.symbolBadId;
    // summary bit must follow the detect bits it is built from
    piSet[`PERR_PI_ERR_DET] = |edSet;
    esSet = '0;
    esSet[`PERR_ES_OUT_DROP] = events.fabricTimeout;
    esSet[`PERR_ES_FATAL] = fatalEvent;
    fabSet = events.fabricTimeout ? events.fabricDest[FAB_W-1:0] : '0;
    giSet = events.fabricTimeout;
  end

  // reads clear status; flags hold until then
  always_comb begin
    piClr = '0;
    edClr = '0;
    esClr = '0;
    fabClr = '0;
    giClr = '0;
    if (readTake) begin
      if (hit(rdAddr, `PERR_OFF_PORT_INT)) piClr = '1;
      if (hit(rdAddr, `PERR_OFF_ERR_DET)) edClr = '1;
      if (hit(rdAddr, `PERR_OFF_ERR_STAT)) esClr = '1;
      if (hit(rdAddr, `PERR_OFF_FAB_INT)) fabClr = '1;
      if (hit(rdAddr, `PERR_OFF_GLB_INT)) giClr = '1;
    end
  end

  perr_sticky #(.W(`PERR_PI_W)) u_port_int (
    .ref_clk(ref_clk), .resetn(resetn), .setBits(piSet), .clrBits(piClr), .flags(portInt)
  );
  perr_sticky #(.W(`PERR_ED_W)) u_err_det (
    .ref_clk(ref_clk), .resetn(resetn), .setBits(edSet), .clrBits(edClr), .flags(errDet)
  );
  perr_sticky #(.W(`PERR_ES_W)) u_err_stat (
    .ref_clk(ref_clk), .resetn(resetn), .setBits(esSet), .clrBits(esClr), .flags(errStat)
  );
  perr_sticky #(.W(FAB_W)) u_fab_int (
    .ref_clk(ref_clk), .resetn(resetn), .setBits(fabSet), .clrBits(fabClr), .flags(fabInt)
  );
  perr_sticky #(.W(`PERR_GI_W)) u_glb_int (
    .ref_clk(ref_clk), .resetn(resetn), .setBits(giSet), .clrBits(giClr), .flags(glbInt)
  );

  always_comb begin
    st_next = st_reg;
    st_next.drop = events.fabricTimeout && st_reg.ctrl[0];
    // write address and data are caught independently
    if (axiReq.awvalid && !st_reg.awHeld) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !st_reg.wHeld) begin
      st_next.wHeld = 1'b1;
      st_next.wData = axiReq.wdata;
      st_next.wStrb = axiReq.wstrb;
    end
    if (writeTake) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = known(st_reg.awAddr) ? `PERR_RESP_OKAY : `PERR_RESP_SLVERR;
      if (st_reg.wStrb[0]) begin
        if (hit(st_reg.awAddr, `PERR_OFF_PORT_MASK)) begin
          st_next.intMask = st_reg.wData[`PERR_PI_W-1:0];
        end
        if (hit(st_reg.awAddr, `PERR_OFF_PW_MASK)) begin
          st_next.pwMask = st_reg.wData[`PERR_PI_W-1:0];
        end
        if (hit(st_reg.awAddr, `PERR_OFF_CTRL)) begin
          st_next.ctrl = st_reg.wData[1:0];
        end
      end
    end
    if (st_reg.bValid && axiReq.bready) begin
      st_next.bValid = 1'b0;
    end
    if (st_reg.rValid && axiReq.rready) begin
      st_next.rValid = 1'b0;
    end
    if (readTake) begin
      st_next.rValid = 1'b1;
      st_next.rResp = known(rdAddr) ? `PERR_RESP_OKAY : `PERR_RESP_SLVERR;
      st_next.rData = 32'h0000_0000;
      if (hit(rdAddr, `PERR_OFF_PORT_INT)) st_next.rData[`PERR_PI_W-1:0] = portInt;
      if (hit(rdAddr, `PERR_OFF_PORT_MASK)) st_next.rData[`PERR_PI_W-1:0] = st_reg.intMask;
      if (hit(rdAddr, `PERR_OFF_ERR_DET)) st_next.rData[`PERR_ED_W-1:0] = errDet;
      if (hit(rdAddr, `PERR_OFF_ERR_STAT)) st_next.rData[`PERR_ES_W-1:0] = errStat;
      if (hit(rdAddr, `PERR_OFF_FAB_INT)) st_next.rData[FAB_W-1:0] = fabInt;
      if (hit(rdAddr, `PERR_OFF_GLB_INT)) st_next.rData[`PERR_GI_W-1:0] = glbInt;
      if (hit(rdAddr, `PERR_OFF_PW_MASK)) st_next.rData[`PERR_PI_W-1:0] = st_reg.pwMask;
      if (hit(rdAddr, `PERR_OFF_CTRL)) st_next.rData[1:0] = st_reg.ctrl;
      if (hit(rdAddr, `PERR_OFF_RETRY)) st_next.rData[6:0] = {toCount, 1'b0, respCount};
    end
    // port-write request level until the messaging engine takes it
    if (portWriteAck) begin
      st_next.pwPending = 1'b0;
    end
    if (st_reg.ctrl[1] && |(piSet & st_reg.pwMask)) begin
      st_next.pwPending = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.intMask <= `PERR_MASK_RST;
      st_reg.pwMask <= `PERR_MASK_RST;
      st_reg.ctrl <= `PERR_CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign irq = |(portInt & st_reg.intMask);
  assign portWriteReq = st_reg.pwPending;
  assign dropPacket = st_reg.drop;

  always_comb begin
    axiRsp = '0;
    axiRsp.awready = !st_reg.awHeld;
    axiRsp.wready = !st_reg.wHeld;
    axiRsp.bvalid = st_reg.bValid;
    axiRsp.bresp = st_reg.bResp;
    axiRsp.arready = !st_reg.rValid;
    axiRsp.rvalid = st_reg.rValid;
    axiRsp.rdata = st_reg.rData;
    axiRsp.rresp = st_reg.rResp;
  end
endmodule : perr_port_events
`default_nettype wire

// *** hdl/perr_retry_tracker.sv ***
// counts successive failed link-request attempts toward a fatal fault
`default_nettype none
`include "perr_defs.svh"
module perr_retry_tracker #(
  parameter logic [2:0] TRIES = `PERR_FATAL_TRIES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // link-request outcomes
  input wire logic attemptFailed,
  input wire logic attemptGood,
  input wire logic clearDead,
  // result
  output logic fatalPulse,
  output logic [2:0] failCount
);
  typedef struct packed {
    perr_pkg::perr_retry_state_t state;
    logic [2:0] count;
    logic fatal;
  } perr_retry_reg_t;

  perr_retry_reg_t st_reg;
  perr_retry_reg_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.fatal = 1'b0;
    unique case (st_reg.state)
      perr_pkg::PERR_IDLE, perr_pkg::PERR_TRY: begin
        if (attemptGood) begin
          st_next.count = 3'h0;
          st_next.state = perr_pkg::PERR_IDLE;
        end else if (attemptFailed) begin
          if (st_reg.count == TRIES - 3'h1) begin
            st_next.fatal = 1'b1;
            st_next.count = TRIES;
            st_next.state = perr_pkg::PERR_DEAD;
          end else begin
            st_next.count = st_reg.count + 3'h1;
            st_next.state = perr_pkg::PERR_TRY;
          end
        end
      end
      perr_pkg::PERR_DEAD: begin
        // stays dead until link recovers or software releases it
        if (attemptGood || clearDead) begin
          st_next.count = 3'h0;
          st_next.state = perr_pkg::PERR_IDLE;
        end
      end
      default: begin
        st_next.state = perr_pkg::PERR_IDLE;
        st_next.count = 3'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '{state: perr_pkg::PERR_IDLE, count: 3'h0, fatal: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign fatalPulse = st_reg.fatal;
  assign failCount = st_reg.count;
endmodule : perr_retry_tracker
`default_nettype wire

// *** hdl/perr_sticky.sv ***
// bank of sticky flags: set wins over clear
`default_nettype none
module perr_sticky #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // set and clear
  input wire logic [W-1:0] setBits,
  input wire logic [W-1:0] clrBits,
  // flags
  output logic [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } perr_sticky_state_t;

  perr_sticky_state_t st_reg;
  perr_sticky_state_t st_next;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < W; i++) begin
      if (setBits[i]) begin
        st_next.flags[i] = 1'b1;
      end else if (clrBits[i]) begin
        st_next.flags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;
endmodule : perr_sticky
`default_nettype wire

// *** pkg/perr_defs.svh ***
// register offsets, field positions, reset values and counts for port event reporting
`ifndef PERR_DEFS_SVH
`define PERR_DEFS_SVH
`define PERR_ADDR_W 8
`define PERR_OFF_PORT_INT 8'h00
`define PERR_OFF_PORT_MASK 8'h04
`define PERR_OFF_ERR_DET 8'h08
`define PERR_OFF_ERR_STAT 8'h0c
`define PERR_OFF_FAB_INT 8'h10
`define PERR_OFF_GLB_INT 8'h14
`define PERR_OFF_PW_MASK 8'h18
`define PERR_OFF_CTRL 8'h1c
`define PERR_OFF_RETRY 8'h20
// port interrupt status bits
`define PERR_PI_FABRIC_TO 0
`define PERR_PI_MCAST_TO 1
`define PERR_PI_PEER_READY 2
`define PERR_PI_FATAL 3
`define PERR_PI_ERR_DET 4
`define PERR_PI_W 5
// error detect bits
`define PERR_ED_ACK_TO 0
`define PERR_ED_BAD_RESP 1
`define PERR_ED_SYM_BAD 2
`define PERR_ED_W 3
// error and status bits
`define PERR_ES_OUT_DROP 0
`define PERR_ES_FATAL 1
`define PERR_ES_W 2
// global interrupt bits
`define PERR_GI_FABRIC_TO 0
`define PERR_GI_W 1
`define PERR_MASK_RST 5'h00
`define PERR_CTRL_RST 2'h3
`define PERR_FATAL_TRIES 3'h4
`define PERR_RESP_OKAY 2'b00
`define PERR_RESP_SLVERR 2'b10
`endif

// *** pkg/perr_pkg.sv ***
// types shared by port event reporting files
`default_nettype none
package perr_pkg;
  typedef struct packed {
    logic fabricTimeout;
    logic mcastTimeout;
    logic [3:0] fabricDest;
    logic linkReqResp;
    logic responseNoAck;
    logic linkReqTimeout;
    logic linkReqIssued;
    logic linkLossExpired;
    logic [3:0] laneAlignExpired;
    logic peerReady;
    logic symbolBadId;
  } perr_events_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } perr_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } perr_axi_rsp_t;

  typedef enum logic [1:0] {
    PERR_IDLE = 2'b00,
    PERR_TRY = 2'b01,
    PERR_DEAD = 2'b10
  } perr_retry_state_t;
endpackage : perr_pkg
`default_nettype wire

// *** testbench/perr_link_model.sv ***
// link partner and fabric model: event pulses and port-write service
`default_nettype none
module perr_link_model #(
  parameter logic [2:0] ACK_DLY = 3'h5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // bench request
  input wire logic cmdStb,
  input wire logic [3:0] cmdCode,
  input wire logic [3:0] cmdArg,
  // toward the block
  output perr_pkg::perr_events_t events,
  input wire logic portWriteReq,
  output logic portWriteAck
);
  logic [2:0] ackWait;
  // every event is a single-cycle pulse
  always_ff @(posedge ref_clk) begin
    events <= '0;
    if (cmdStb) begin
      case (cmdCode)
        4'h0: begin
          events.fabricTimeout <= 1'b1;
          events.fabricDest <= cmdArg;
        end
        4'h1: events.mcastTimeout <= 1'b1;
        4'h2: begin
          events.linkReqResp <= 1'b1;
          events.responseNoAck <= 1'b1;
        end
        4'h3: events.linkReqTimeout <= 1'b1;
        4'h4: events.linkLossExpired <= 1'b1;
        4'h5: events.laneAlignExpired <= cmdArg;
        4'h6: events.peerReady <= 1'b1;
        4'h7: events.symbolBadId <= 1'b1;
        default: events.linkReqResp <= 1'b1;
      endcase
    end
  end
  // slow host: acknowledge only after some cycles
  always_ff @(posedge ref_clk) begin
    portWriteAck <= 1'b0;
    ackWait <= portWriteReq ? ackWait + 3'h1 : 3'h0;
    if (!resetn) begin
      ackWait <= 3'h0;
    end else if (ackWait == ACK_DLY) begin
      portWriteAck <= 1'b1;
      ackWait <= 3'h0;
    end
  end
endmodule : perr_link_model
`default_nettype wire

// *** testbench/perr_port_events_assertions.sv ***
// checker for the port event reporting block
`default_nettype none
module perr_port_events_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // watched ports
  input wire perr_pkg::perr_events_t events,
  input wire logic dropPacket,
  input wire perr_pkg::perr_axi_req_t axiReq,
  input wire perr_pkg::perr_axi_rsp_t axiRsp,
  input wire logic irq,
  input wire logic portWriteReq,
  input wire logic portWriteAck
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_DROP: assert property (dropPacket |-> $past(events.fabricTimeout))
    else $error("drop without a fabric timeout");
  AST_RD_LAT: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  AST_WR_LAT: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready |-> ##[1:3] axiRsp.bvalid)
    else $error("write answer late");
  AST_R_HOLD: assert property (axiRsp.rvalid && !axiReq.rready |=>
    axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read answer not held");
  AST_B_HOLD: assert property (axiRsp.bvalid && !axiReq.bready |=>
    axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write answer not held");
  AST_AR_RDY: assert property (axiRsp.arready == !axiRsp.rvalid)
    else $error("arready not the inverse of rvalid");
  AST_PW_HOLD: assert property (portWriteReq && !portWriteAck |=> portWriteReq)
    else $error("port-write request dropped unserviced");
  AST_IRQ_HOLD: assert property (irq && !axiReq.arvalid && !axiReq.awvalid
    && !$past(axiReq.awvalid) && !$past(axiReq.wvalid) |=> irq)
    else $error("interrupt fell without software");
  COV_DROP: cover property (dropPacket);
  COV_IRQ: cover property ($rose(irq));
  COV_PW: cover property ($rose(portWriteReq));
endmodule : perr_port_events_assertions
bind perr_port_events perr_port_events_assertions i_perr_port_events_assertions (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .events(events),
  .dropPacket(dropPacket),
  .axiReq(axiReq),
  .axiRsp(axiRsp),
  .irq(irq),
  .portWriteReq(portWriteReq),
  .portWriteAck(portWriteAck)
);
`default_nettype wire

// *** testbench/perr_port_events_tb.sv ***
// self-checking bench for port event reporting
`default_nettype none
`include "perr_defs.svh"
module perr_port_events_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmdStb = 1'b0;
  logic [3:0] cmdCode = 4'h0;
  logic [3:0] cmdArg = 4'h0;
  perr_pkg::perr_events_t events;
  perr_pkg::perr_axi_req_t axiReq = '0;
  perr_pkg::perr_axi_rsp_t axiRsp;
  logic dropPacket, irq, portWriteReq, portWriteAck;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [1:0] bs;
  int n_fail = 0;
  int check_count = 0;
  int drops = 0;
  int pwCyc = 0;
  int cod[9] = '{1, 2, 2, 3, 3, 4, 5, 6, 7};
  int cnt[9] = '{1, 3, 4, 3, 4, 1, 1, 1, 1};
  perr_port_events i_perr_port_events (.ref_clk(ref_clk), .resetn(resetn),
    .events(events), .dropPacket(dropPacket), .axiReq(axiReq), .axiRsp(axiRsp),
    .irq(irq), .portWriteReq(portWriteReq), .portWriteAck(portWriteAck));
  perr_link_model i_perr_link_model (.ref_clk(ref_clk), .resetn(resetn), .cmdStb(cmdStb),
    .cmdCode(cmdCode), .cmdArg(cmdArg), .events(events), .portWriteReq(portWriteReq),
    .portWriteAck(portWriteAck));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (dropPacket === 1'b1) drops++;
    if (portWriteReq === 1'b1) pwCyc++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (axiReq.awvalid && axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
      t++;
      if (axiRsp.bvalid === 1'b1 || t > 50) break;
    end
    if (t > 50) n_fail++;
    bs = axiRsp.bresp;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    int t;
    t = 0;
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (axiReq.arvalid && axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
      t++;
      if (axiRsp.rvalid === 1'b1 || t > 50) break;
    end
    if (t > 50) n_fail++;
    rd = axiRsp.rdata;
    rs = axiRsp.rresp;
  endtask : rdr
  task automatic fire(input int c, input logic [3:0] a);
    cmdCode <= 4'(c);
    cmdArg <= a;
    cmdStb <= 1'b1;
    @(posedge ref_clk);
    cmdStb <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : fire
  // {port int, error detect, error status} after n events of one kind
  function automatic logic [9:0] exp_regs(input int c, input int n);
    logic f;
    f = (n >= 4);
    case (c)
      1: return 10'h040;
      2: return {1'b1, f, 3'h0, 3'h2, f, 1'b0};
      3: return {1'b1, f, 3'h0, 3'h1, f, 1'b0};
      4, 5: return {5'h08, 3'h0, 2'h2};
      6: return {5'h04, 5'h00};
      default: return {5'h10, 3'h4, 2'h0};
    endcase
  endfunction : exp_regs
  initial begin
    logic [4:0] m;
    logic [3:0] a;
    logic [9:0] e;
    int d0;
    void'($urandom(84147));
    axiReq.rready <= 1'b1;
    axiReq.bready <= 1'b1;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    // reset values, last one unmapped
    for (int i = 0; i < 10; i++) begin
      rdr(8'(i * 4));
      check({30'h0, rs}, (i == 9) ? {30'h0, `PERR_RESP_SLVERR} : 32'h0);
      check(rd, (i == 7) ? 32'h3 : 32'h0);
    end
    wr(8'h24, 32'h0);
    check({30'h0, bs}, {30'h0, `PERR_RESP_SLVERR});
    // fabric timeout, random mask, drop disabled on the middle pass
    for (int k = 0; k < 3; k++) begin
      m = 5'($urandom);
      a = 4'($urandom_range(15, 1));
      wr(`PERR_OFF_PORT_MASK, {27'h0, m});
      check({30'h0, bs}, 32'h0);
      wr(`PERR_OFF_CTRL, (k == 1) ? 32'h2 : 32'h3);
      d0 = drops;
      fire(0, a);
      check(32'(drops - d0), (k == 1) ? 32'h0 : 32'h1);
      check({31'h0, irq}, {31'h0, m[0]});
      rdr(`PERR_OFF_PORT_INT);
      check(rd, 32'h1);
      rdr(`PERR_OFF_ERR_STAT);
      check(rd, 32'h1);
      rdr(`PERR_OFF_FAB_INT);
      check(rd, {28'h0, a});
      rdr(`PERR_OFF_GLB_INT);
      check(rd, 32'h1);
      rdr(`PERR_OFF_PORT_INT);
      check(rd, 32'h0);
    end
    // every other event kind, fatal counts at three and four
    wr(`PERR_OFF_PORT_MASK, 32'h1f);
    for (int i = 0; i < 9; i++) begin
      for (int j = 0; j < cnt[i]; j++) fire(cod[i], 4'($urandom_range(15, 1)));
      check({31'h0, irq}, 32'h1);
      e = exp_regs(cod[i], cnt[i]);
      rdr(`PERR_OFF_PORT_INT);
      check(rd, {27'h0, e[9:5]});
      rdr(`PERR_OFF_ERR_DET);
      check(rd, {29'h0, e[4:2]});
      rdr(`PERR_OFF_ERR_STAT);
      check(rd, {30'h0, e[1:0]});
      wr(`PERR_OFF_ERR_STAT, 32'h0);
      check({31'h0, irq}, 32'h0);
    end
    // a good response breaks the run of failed tries
    for (int c = 2; c < 4; c++) begin
      repeat (3) fire(c, 4'h0);
      fire(8, 4'h0);
      fire(c, 4'h0);
      rdr(`PERR_OFF_ERR_STAT);
      check(rd, 32'h0);
      rdr(`PERR_OFF_RETRY);
      check(rd, (c == 2) ? 32'h1 : 32'h10);
      rdr(`PERR_OFF_PORT_INT);
      check(rd, 32'h10);
      rdr(`PERR_OFF_ERR_DET);
      check(rd, (c == 2) ? 32'h2 : 32'h1);
    end
    // peer ready with port-write, serviced late by the host
    wr(`PERR_OFF_PW_MASK, 32'h4);
    d0 = pwCyc;
    fire(6, 4'h0);
    for (int t = 0; t < 40 && portWriteReq !== 1'b0; t++) @(posedge ref_clk);
    check(32'(pwCyc - d0 > 0), 32'h1);
    check({31'h0, portWriteReq}, 32'h0);
    check({31'h0, irq}, 32'h1);
    rdr(`PERR_OFF_PORT_INT);
    check(rd, 32'h4);
    // port-writes switched off: the same event must raise no port-write request
    wr(`PERR_OFF_CTRL, 32'h1);
    d0 = pwCyc;
    fire(6, 4'h0);
    check(32'(pwCyc - d0), 32'h0);
    finish_test();
  end
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end
endmodule : perr_port_events_tb
`default_nettype wire
